//--- fsfc_defs.vh
`ifndef FSFC_DEFS_VH
`define FSFC_DEFS_VH

// data path geometry
`define FSFC_DATA_W 18
`define FSFC_BYTE_W 9
`define FSFC_OFF_W 17
`define FSFC_ADDR_W 17

// register byte offsets
`define FSFC_REG_CONFIG 8'h00
`define FSFC_REG_STATUS 8'h04
`define FSFC_REG_EMPTY_OFFSET 8'h08
`define FSFC_REG_FULL_OFFSET 8'h0c
`define FSFC_REG_LEVEL 8'h10

// config register bits (straps captured at master reset)
`define FSFC_CFG_LITTLE_ENDIAN 0
`define FSFC_CFG_SYNC_FLAGS 1
`define FSFC_CFG_INTER_PARITY 2
`define FSFC_CFG_FALL_THROUGH 3
`define FSFC_CFG_IN_NARROW 4
`define FSFC_CFG_OUT_NARROW 5

// status register bits
`define FSFC_ST_FULL_N 0
`define FSFC_ST_EMPTY_N 1
`define FSFC_ST_ALMOST_FULL_N 2
`define FSFC_ST_ALMOST_EMPTY_N 3
`define FSFC_ST_MEM_FULL 4
`define FSFC_ST_MEM_EMPTY 5
`define FSFC_ST_OUT_VALID 6

// offset values loaded at master reset
`define FSFC_DEF_EMPTY_OFFSET 17'h0007f
`define FSFC_DEF_FULL_OFFSET 17'h0007f

// pin synchroniser vector layout
`define FSFC_PIN_W 8
`define FSFC_PIN_MASTER_RST 7
`define FSFC_PIN_PARTIAL_RST 6
`define FSFC_PIN_BYTE_ORDER 5
`define FSFC_PIN_FLAG_TIMING 4
`define FSFC_PIN_PARITY 3
`define FSFC_PIN_FALL_THROUGH 2
`define FSFC_PIN_IN_WIDTH 1
`define FSFC_PIN_OUT_WIDTH 0

`endif

//--- fsfc_pin_sync.v
`timescale 1ns/10ps
module fsfc_pin_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // pins in
  input wire [WIDTH-1:0] pinIn,
  // filtered levels out
  output wire [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] level_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a level counts only once two settled stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          level_reg[i] <= 1'b0;
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          level_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

  assign pinOut = level_reg;

endmodule

//--- fsfc_mem.v
`timescale 1ns/10ps
module fsfc_mem #(
  parameter AW = 17
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // write port, one enable per byte lane
  input wire weHi,
  input wire weLo,
  input wire [AW-1:0] waddr,
  input wire [17:0] wdata,
  // read port
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [17:0] rdata
);

  reg [17:0] store [0:(1<<AW)-1];

  // array has no reset: only pointers decide what is valid
  always @(posedge ref_clk) begin
    if (weHi) begin
      store[waddr][17:9] <= wdata[17:9];
    end
    if (weLo) begin
      store[waddr][8:0] <= wdata[8:0];
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 18'h00000;
    end else if (re) begin
      rdata <= store[raddr];
    end
  end

endmodule

//--- fsfc_flags.v
`timescale 1ns/10ps
`include "fsfc_defs.vh"
module fsfc_flags #(
  parameter ADDR_W = `FSFC_ADDR_W,
  parameter [16:0] DEF_EMPTY_OFFSET = `FSFC_DEF_EMPTY_OFFSET,
  parameter [16:0] DEF_FULL_OFFSET = `FSFC_DEF_FULL_OFFSET
) (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // reset and strap pins
  input wire master_reset_n,
  input wire partial_reset_n,
  input wire byte_order_select_n,
  input wire flag_timing_select,
  input wire parity_position_select,
  input wire fall_through_or_serial_in,
  input wire input_width_select,
  input wire output_width_select,
  // write side
  input wire wrEnable,
  input wire [17:0] wrData,
  // read side
  input wire rdEnable,
  output reg [17:0] rdData,
  // status flags
  output reg fullFlagN,
  output reg emptyFlagN,
  output reg almostFullN,
  output reg almostEmptyN
);

  localparam PW = ADDR_W + 2;
  localparam CW = PW + `FSFC_OFF_W;
  localparam [PW-1:0] CAP_BYTES = {1'b1, {(ADDR_W+1){1'b0}}};

  // pin synchronisation
  wire [`FSFC_PIN_W-1:0] pinLevel;
  fsfc_pin_sync #(
    .WIDTH(`FSFC_PIN_W)
  ) uPinSync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pinIn({master_reset_n, partial_reset_n, byte_order_select_n, flag_timing_select,
            parity_position_select, fall_through_or_serial_in, input_width_select,
            output_width_select}),
    .pinOut(pinLevel)
  );

  wire masterRstActive = !pinLevel[`FSFC_PIN_MASTER_RST];
  wire partialRstActive = !pinLevel[`FSFC_PIN_PARTIAL_RST];
  wire resetting = masterRstActive | partialRstActive;

  // captured configuration
  reg littleEndian_reg;
  reg syncFlags_reg;
  reg interParity_reg;
  reg fallThrough_reg;
  reg inNarrow_reg;
  reg outNarrow_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      littleEndian_reg <= 1'b0;
      syncFlags_reg <= 1'b0;
      interParity_reg <= 1'b0;
      fallThrough_reg <= 1'b0;
      inNarrow_reg <= 1'b0;
      outNarrow_reg <= 1'b0;
    end else if (masterRstActive) begin
      // last level seen before the release is the one kept
      littleEndian_reg <= pinLevel[`FSFC_PIN_BYTE_ORDER];
      syncFlags_reg <= pinLevel[`FSFC_PIN_FLAG_TIMING];
      interParity_reg <= pinLevel[`FSFC_PIN_PARITY];
      fallThrough_reg <= pinLevel[`FSFC_PIN_FALL_THROUGH];
      inNarrow_reg <= pinLevel[`FSFC_PIN_IN_WIDTH];
      outNarrow_reg <= pinLevel[`FSFC_PIN_OUT_WIDTH];
    end
  end

  // pointers count bytes so every width mix shares one scheme
  reg [PW-1:0] wptr_reg;
  reg [PW-1:0] rptr_reg;
  reg pend_reg;
  reg laneHi_reg;
  reg outValid_reg;
  reg wrDone_reg;
  reg rdDone_reg;

  wire wide = !inNarrow_reg | !outNarrow_reg;
  wire [PW-1:0] wrBytes = {{(PW-2){1'b0}}, (inNarrow_reg ? 2'h1 : 2'h2)};
  wire [PW-1:0] rdBytes = {{(PW-2){1'b0}}, (outNarrow_reg ? 2'h1 : 2'h2)};
  wire [PW-1:0] bytesUsed = wptr_reg - rptr_reg;
  wire [PW-1:0] freeBytes = CAP_BYTES - bytesUsed;
  wire memFull = freeBytes < wrBytes;
  wire memEmpty = bytesUsed < rdBytes;

  wire wrAccept = wrEnable & !memFull & !resetting;
  wire rdAccept = rdEnable & !memEmpty & !resetting & !fallThrough_reg;
  wire popOut = rdEnable & outValid_reg & !resetting & fallThrough_reg;
  wire fetch = fallThrough_reg & !memEmpty & !pend_reg & !resetting &
               (!outValid_reg | popOut);
  wire memRead = rdAccept | fetch;

  // big-endian puts byte 0 of a word in the high lane
  wire wrHiLane = (wptr_reg[0] == littleEndian_reg);
  wire rdHiLane = (rptr_reg[0] == littleEndian_reg);
  wire memWeHi = wrAccept & (!inNarrow_reg | wrHiLane);
  wire memWeLo = wrAccept & (!inNarrow_reg | !wrHiLane);
  wire [17:0] memWdata = inNarrow_reg ? {wrData[8:0], wrData[8:0]} : wrData;
  wire [17:0] memRdata;

  fsfc_mem #(
    .AW(ADDR_W)
  ) uMem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .weHi(memWeHi),
    .weLo(memWeLo),
    .waddr(wptr_reg[ADDR_W:1]),
    .wdata(memWdata),
    .re(memRead),
    .raddr(rptr_reg[ADDR_W:1]),
    .rdata(memRdata)
  );

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg <= {PW{1'b0}};
      rptr_reg <= {PW{1'b0}};
      pend_reg <= 1'b0;
      laneHi_reg <= 1'b0;
      outValid_reg <= 1'b0;
      wrDone_reg <= 1'b0;
      rdDone_reg <= 1'b0;
      rdData <= 18'h00000;
    end else if (resetting) begin
      // data go, configuration stays through a partial reset
      wptr_reg <= {PW{1'b0}};
      rptr_reg <= {PW{1'b0}};
      pend_reg <= 1'b0;
      outValid_reg <= 1'b0;
      wrDone_reg <= 1'b0;
      rdDone_reg <= 1'b0;
    end else begin
      wrDone_reg <= wrAccept;
      rdDone_reg <= rdAccept | popOut;
      if (wrAccept) begin
        wptr_reg <= wptr_reg + wrBytes;
      end
      if (memRead) begin
        rptr_reg <= rptr_reg + rdBytes;
        laneHi_reg <= rdHiLane;
      end
      pend_reg <= memRead;
      if (pend_reg) begin
        if (outNarrow_reg) begin
          rdData <= {9'h000, (laneHi_reg ? memRdata[17:9] : memRdata[8:0])};
        end else begin
          rdData <= memRdata;
        end
        outValid_reg <= fallThrough_reg;
      end else if (popOut) begin
        // the word just read stays visible on rdData
        outValid_reg <= 1'b0;
      end
    end
  end

  // level in units of the wider port, output register included in fall-through mode only
  wire [PW-1:0] totalBytes = bytesUsed +
    ((fallThrough_reg & (outValid_reg | pend_reg)) ? rdBytes : {PW{1'b0}});
  wire [PW-1:0] units = wide ? {1'b0, totalBytes[PW-1:1]} : totalBytes;
  wire [PW-1:0] capUnits = wide ? {1'b0, CAP_BYTES[PW-1:1]} : CAP_BYTES;

  reg [16:0] emptyOffset_reg;
  reg [16:0] fullOffset_reg;

  wire [CW-1:0] unitsC = {{(CW-PW){1'b0}}, units};
  wire [CW-1:0] capC = {{(CW-PW){1'b0}}, capUnits};
  wire [CW-1:0] fullOffC = {{(CW-17){1'b0}}, fullOffset_reg};
  wire [CW-1:0] emptyOffC = {{(CW-17){1'b0}}, emptyOffset_reg};
  wire [CW-1:0] ftC = {{(CW-1){1'b0}}, fallThrough_reg};
  // sums instead of differences so a large offset cannot wrap
  wire almostFullCond = (unitsC + fullOffC) >= (capC + ftC);
  wire almostEmptyCond = unitsC <= (emptyOffC + ftC);

  // flag pipelines
  reg fullStage1_reg;
  reg emptyStage1_reg;
  reg emptyStage2_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fullStage1_reg <= 1'b0;
      fullFlagN <= 1'b1;
      emptyStage1_reg <= 1'b1;
      emptyStage2_reg <= 1'b1;
      emptyFlagN <= 1'b0;
      almostFullN <= 1'b1;
      almostEmptyN <= 1'b0;
    end else if (resetting) begin
      fullStage1_reg <= 1'b0;
      fullFlagN <= !fallThrough_reg;
      emptyStage1_reg <= 1'b1;
      emptyStage2_reg <= 1'b1;
      emptyFlagN <= fallThrough_reg;
      almostFullN <= 1'b1;
      almostEmptyN <= 1'b0;
    end else begin
      fullStage1_reg <= memFull;
      fullFlagN <= fallThrough_reg ? fullStage1_reg : !fullStage1_reg;
      emptyStage1_reg <= fallThrough_reg ? !outValid_reg : memEmpty;
      emptyStage2_reg <= emptyStage1_reg;
      if (fallThrough_reg) begin
        emptyFlagN <= emptyStage2_reg;
      end else begin
        emptyFlagN <= !emptyStage1_reg;
      end
      if (syncFlags_reg) begin
        almostFullN <= !almostFullCond;
        almostEmptyN <= !almostEmptyCond;
      end else begin
        // the level only rises on writes and falls on reads
        if (almostFullCond & wrDone_reg) begin
          almostFullN <= 1'b0;
        end else if (!almostFullCond & rdDone_reg) begin
          almostFullN <= 1'b1;
        end
        if (almostEmptyCond & rdDone_reg) begin
          almostEmptyN <= 1'b0;
        end else if (!almostEmptyCond & wrDone_reg) begin
          almostEmptyN <= 1'b1;
        end
      end
    end
  end

  // offset load and readback through the parity layout
  function [16:0] offLoad;
    input [17:0] d;
    input ip;
    begin
      if (ip) begin
        offLoad = {d[17:9], d[7:0]};
      end else begin
        offLoad = {1'b0, d[15:0]};
      end
    end
  endfunction

  function [17:0] offRead;
    input [16:0] v;
    input ip;
    begin
      if (ip) begin
        offRead = {v[16:8], 1'b0, v[7:0]};
      end else begin
        offRead = {2'b00, v[15:0]};
      end
    end
  endfunction

  // apb: zero wait states, read data latched in the setup cycle
  wire apbSetup = psel & !penable;
  wire apbWrite = psel & penable & pwrite;
  wire mapped = (paddr == `FSFC_REG_CONFIG) | (paddr == `FSFC_REG_STATUS) |
                (paddr == `FSFC_REG_EMPTY_OFFSET) | (paddr == `FSFC_REG_FULL_OFFSET) |
                (paddr == `FSFC_REG_LEVEL);
  assign pready = 1'b1;

  reg [31:0] readMux;
  always @* begin
    readMux = 32'h00000000;
    case (paddr)
      `FSFC_REG_CONFIG: begin
        readMux[`FSFC_CFG_LITTLE_ENDIAN] = littleEndian_reg;
        readMux[`FSFC_CFG_SYNC_FLAGS] = syncFlags_reg;
        readMux[`FSFC_CFG_INTER_PARITY] = interParity_reg;
        readMux[`FSFC_CFG_FALL_THROUGH] = fallThrough_reg;
        readMux[`FSFC_CFG_IN_NARROW] = inNarrow_reg;
        readMux[`FSFC_CFG_OUT_NARROW] = outNarrow_reg;
      end
      `FSFC_REG_STATUS: begin
        readMux[`FSFC_ST_FULL_N] = fullFlagN;
        readMux[`FSFC_ST_EMPTY_N] = emptyFlagN;
        readMux[`FSFC_ST_ALMOST_FULL_N] = almostFullN;
        readMux[`FSFC_ST_ALMOST_EMPTY_N] = almostEmptyN;
        readMux[`FSFC_ST_MEM_FULL] = memFull;
        readMux[`FSFC_ST_MEM_EMPTY] = memEmpty;
        readMux[`FSFC_ST_OUT_VALID] = outValid_reg;
      end
      `FSFC_REG_EMPTY_OFFSET: begin
        readMux = {14'h0000, offRead(emptyOffset_reg, interParity_reg)};
      end
      `FSFC_REG_FULL_OFFSET: begin
        readMux = {14'h0000, offRead(fullOffset_reg, interParity_reg)};
      end
      `FSFC_REG_LEVEL: begin
        readMux = {{(32-PW){1'b0}}, units};
      end
      default: begin
        readMux = 32'h00000000;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      emptyOffset_reg <= DEF_EMPTY_OFFSET;
      fullOffset_reg <= DEF_FULL_OFFSET;
    end else begin
      if (apbSetup) begin
        prdata <= pwrite ? 32'h00000000 : readMux;
        pslverr <= !mapped;
      end
      if (masterRstActive) begin
        // only master reset restores offsets
        emptyOffset_reg <= DEF_EMPTY_OFFSET;
        fullOffset_reg <= DEF_FULL_OFFSET;
      end else if (apbWrite & (paddr == `FSFC_REG_EMPTY_OFFSET)) begin
        emptyOffset_reg <= offLoad(pwdata[17:0], interParity_reg);
      end else if (apbWrite & (paddr == `FSFC_REG_FULL_OFFSET)) begin
        fullOffset_reg <= offLoad(pwdata[17:0], interParity_reg);
      end
    end
  end

endmodule

//--- fsfc_flags_checker.sv
`timescale 1ns/10ps
`include "fsfc_defs.vh"
module fsfc_flags_checker (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins
  input wire master_reset_n,
  input wire partial_reset_n,
  input wire flag_timing_select,
  input wire fall_through_or_serial_in,
  input wire wrEnable,
  input wire rdEnable,
  // flags
  input wire fullFlagN,
  input wire emptyFlagN,
  input wire almostFullN,
  input wire almostEmptyN
);
  reg [3:0] quietCnt_reg;
  reg ftMode_reg;
  reg syncMode_reg;
  // flag edges right after a reset are forced, not caused by traffic
  wire quiet = (quietCnt_reg == 4'hf);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      quietCnt_reg <= 4'h0;
      ftMode_reg <= 1'b0;
      syncMode_reg <= 1'b0;
    end else begin
      if (!master_reset_n) begin
        ftMode_reg <= fall_through_or_serial_in;
        syncMode_reg <= flag_timing_select;
      end
      if (!master_reset_n || !partial_reset_n) quietCnt_reg <= 4'h0;
      else if (!quiet) quietCnt_reg <= quietCnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_error: assert property (psel && penable && paddr >= 8'h14 |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_no_error: assert property (psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped access");
  a_status_read: assert property (psel && penable && !pwrite && paddr == `FSFC_REG_STATUS
    |-> prdata[0] == $past(fullFlagN) && prdata[1] == $past(emptyFlagN)
    && prdata[2] == $past(almostFullN) && prdata[3] == $past(almostEmptyN))
    else $error("status bits differ from flags");
  a_reset_forces: assert property (!master_reset_n [*8]
    |-> almostFullN && !almostEmptyN && fullFlagN != emptyFlagN)
    else $error("flags not forced in master reset");
  a_full_cause: assert property (quiet
    && (ftMode_reg ? $rose(fullFlagN) : $fell(fullFlagN))
    |-> $past(wrEnable, 2) || $past(wrEnable, 3) || $past(wrEnable, 4))
    else $error("full flag without write");
  a_empty_set: assert property (quiet && !ftMode_reg && $rose(emptyFlagN)
    |-> $past(wrEnable, 2) || $past(wrEnable, 3) || $past(wrEnable, 4))
    else $error("empty flag cleared without write");
  a_empty_clr: assert property (quiet && !ftMode_reg && $fell(emptyFlagN)
    |-> $past(rdEnable, 2) || $past(rdEnable, 3) || $past(rdEnable, 4))
    else $error("empty flag set without read");
  a_afull_async: assert property (quiet && !syncMode_reg && $fell(almostFullN)
    |-> $past(wrEnable) || $past(wrEnable, 2) || $past(wrEnable, 3))
    else $error("almost full low without write");
  a_aempty_async: assert property (quiet && !syncMode_reg && $fell(almostEmptyN)
    |-> $past(rdEnable) || $past(rdEnable, 2) || $past(rdEnable, 3))
    else $error("almost empty low without read");
endmodule
bind fsfc_flags fsfc_flags_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
  .flag_timing_select(flag_timing_select), .fall_through_or_serial_in(fall_through_or_serial_in),
  .wrEnable(wrEnable), .rdEnable(rdEnable), .fullFlagN(fullFlagN), .emptyFlagN(emptyFlagN),
  .almostFullN(almostFullN), .almostEmptyN(almostEmptyN));

//--- fsfc_reader.sv
`timescale 1ns/10ps
module fsfc_reader (
  // clock
  input wire ref_clk,
  // control and flags
  input wire go,
  input wire emptyFlagN,
  input wire [17:0] rdData,
  // read side
  output logic rdEnable,
  output logic gotData,
  output logic [17:0] gotVal
);
  // single spaced reads so the lagging empty flag is settled before the next one
  initial begin
    rdEnable <= 1'b0;
    gotData <= 1'b0;
    gotVal <= 18'h0;
    forever begin
      @(posedge ref_clk);
      if (go && emptyFlagN === 1'b1) begin
        rdEnable <= 1'b1;
        @(posedge ref_clk);
        rdEnable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        gotVal <= rdData;
        gotData <= 1'b1;
        @(posedge ref_clk);
        gotData <= 1'b0;
        repeat ($urandom % 4) @(posedge ref_clk);
      end
    end
  end
endmodule

//--- fsfc_flags_test.sv
`timescale 1ns/10ps
`include "fsfc_defs.vh"
module fsfc_flags_test;
  reg ref_clk, arst_n, psel, penable, pwrite, wrEnable, go, rdPoke;
  reg [7:0] paddr;
  reg [31:0] pwdata, rv;
  reg [17:0] wrData, d;
  reg master_reset_n, partial_reset_n, byte_order_select_n, flag_timing_select;
  reg parity_position_select, fall_through_or_serial_in, input_width_select, output_width_select;
  wire [31:0] prdata;
  wire [17:0] rdData, gotVal;
  wire pready, pslverr, rdRd, gotData, fullFlagN, emptyFlagN, almostFullN, almostEmptyN;
  wire rdEnable = rdRd | rdPoke;
  logic [17:0] expQ[$];
  logic err;
  int errorCnt = 0;
  int checksDone = 0;
  int i;
  fsfc_flags #(.ADDR_W(4)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .byte_order_select_n(byte_order_select_n),
    .flag_timing_select(flag_timing_select), .parity_position_select(parity_position_select),
    .fall_through_or_serial_in(fall_through_or_serial_in),
    .input_width_select(input_width_select), .output_width_select(output_width_select),
    .wrEnable(wrEnable), .wrData(wrData), .rdEnable(rdEnable), .rdData(rdData),
    .fullFlagN(fullFlagN), .emptyFlagN(emptyFlagN), .almostFullN(almostFullN),
    .almostEmptyN(almostEmptyN));
  fsfc_reader u_rdr (.ref_clk(ref_clk), .go(go), .emptyFlagN(emptyFlagN), .rdData(rdData),
    .rdEnable(rdRd), .gotData(gotData), .gotVal(gotVal));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task wr(input logic [17:0] wd);
    wrEnable <= 1'b1;
    wrData <= wd;
    @(posedge ref_clk);
    wrEnable <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task mreset(input logic [5:0] c);
    master_reset_n <= 1'b0;
    {output_width_select, input_width_select, fall_through_or_serial_in} <= c[5:3];
    {parity_position_select, flag_timing_select, byte_order_select_n} <= c[2:0];
    repeat (8) @(posedge ref_clk);
    master_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, `FSFC_REG_CONFIG, 32'h0);
    cmp(rv, {26'h0, c});
  endtask
  task drain;
    go <= 1'b1;
    for (i = 0; i < 600 && expQ.size() > 0; i++) @(posedge ref_clk);
    go <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp(expQ.size(), 32'h0);
  endtask
  task finishTest;
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (gotData === 1'b1) begin
      if (expQ.size() == 0) cmp({14'h0, gotVal}, 32'hffffffff);
      else cmp({14'h0, gotVal}, {14'h0, expQ.pop_front()});
    end
  end
  initial begin
    #600000;
    errorCnt++;
    finishTest;
  end
  initial begin
    {arst_n, psel, penable, pwrite, wrEnable, go, rdPoke, master_reset_n} <= 8'h0;
    {paddr, pwdata, wrData} <= 58'h0;
    d = 18'h0;
    partial_reset_n <= 1'b1;
    {byte_order_select_n, flag_timing_select, parity_position_select} <= 3'h0;
    {fall_through_or_serial_in, input_width_select, output_width_select} <= 3'h0;
    i = $urandom(99);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    mreset(6'h02);
    apb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, `FSFC_REG_EMPTY_OFFSET, 32'h3ffff);
    apb(1'b0, `FSFC_REG_EMPTY_OFFSET, 32'h0);
    cmp(rv, 32'h0ffff);
    apb(1'b1, `FSFC_REG_EMPTY_OFFSET, 32'h2);
    apb(1'b1, `FSFC_REG_FULL_OFFSET, 32'h3);
    for (int k = 1; k <= 17; k++) begin
      d = $urandom;
      if (k <= 16) expQ.push_back(d);
      wr(d);
      cmp({31'h0, almostFullN}, {31'h0, k < 13});
      cmp({31'h0, fullFlagN}, {31'h0, k < 16});
    end
    apb(1'b0, `FSFC_REG_STATUS, 32'h0);
    cmp({28'h0, rv[3:0]}, 32'ha);
    drain;
    cmp({31'h0, emptyFlagN}, 32'h0);
    cmp({31'h0, almostEmptyN}, 32'h0);
    wr(d);
    wr(d);
    partial_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    partial_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cmp({31'h0, emptyFlagN}, 32'h0);
    apb(1'b0, `FSFC_REG_FULL_OFFSET, 32'h0);
    cmp(rv, 32'h3);
    apb(1'b0, `FSFC_REG_CONFIG, 32'h0);
    cmp(rv, 32'h2);
    $display("standard mode test done");
    for (int e = 0; e < 2; e++) begin
      mreset(6'h20 | e);
      d = $urandom;
      wr(d);
      apb(1'b0, `FSFC_REG_LEVEL, 32'h0);
      cmp(rv, 32'h1);
      expQ.push_back(e ? {9'h0, d[8:0]} : {9'h0, d[17:9]});
      expQ.push_back(e ? {9'h0, d[17:9]} : {9'h0, d[8:0]});
      drain;
    end
    $display("byte order test done");
    mreset(6'h0d);
    cmp({31'h0, fullFlagN}, 32'h0);
    cmp({31'h0, emptyFlagN}, 32'h1);
    apb(1'b1, `FSFC_REG_EMPTY_OFFSET, 32'h3ffff);
    apb(1'b0, `FSFC_REG_EMPTY_OFFSET, 32'h0);
    cmp(rv, 32'h3feff);
    d = $urandom;
    wr(d);
    for (i = 0; i < 30 && emptyFlagN !== 1'b0; i++) @(posedge ref_clk);
    cmp({31'h0, emptyFlagN}, 32'h0);
    cmp({14'h0, rdData}, {14'h0, d});
    rdPoke <= 1'b1;
    @(posedge ref_clk);
    rdPoke <= 1'b0;
    repeat (8) @(posedge ref_clk);
    cmp({31'h0, emptyFlagN}, 32'h1);
    cmp({14'h0, rdData}, {14'h0, d});
    apb(1'b1, `FSFC_REG_EMPTY_OFFSET, 32'h2);
    apb(1'b1, `FSFC_REG_FULL_OFFSET, 32'h3);
    // asynchronous flags ignore offset changes, so a partial reset restarts them
    partial_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    partial_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int k = 1; k <= 18; k++) begin
      d = $urandom;
      wr(d);
      cmp({31'h0, fullFlagN}, {31'h0, k >= 17});
      cmp({31'h0, almostFullN}, {31'h0, k < 14});
      cmp({31'h0, almostEmptyN}, {31'h0, k >= 4});
    end
    $display("fall-through test done");
    finishTest;
  end
endmodule
